/* File: hw/pas_params.svh */
`ifndef PAS_PARAMS_SVH
`define PAS_PARAMS_SVH

`define PAS_CODE_W          10
`define PAS_IN_W            12
`define PAS_LATENCY         4
`define PAS_FIFO_DEPTH      16
`define PAS_ADDR_W          4
`define PAS_DATA_W          32

`define PAS_REG_CTRL        4'h0
`define PAS_REG_STATUS      4'h4
`define PAS_REG_DATA        4'h8
`define PAS_REG_LEVEL       4'hC

`define PAS_CTRL_CAPTURE    0
`define PAS_CTRL_FLUSH      1
`define PAS_CTRL_RST        1'h0

`define PAS_ST_OVERFLOW     0
`define PAS_ST_EMPTY        1
`define PAS_ST_FULL         2
`define PAS_ST_PWRDN        3
`define PAS_ST_EXT_REF      4
`define PAS_ST_BIAS_ON      5
`define PAS_ST_BANDGAP_ON   6
`define PAS_ST_VALID        7
`define PAS_ST_MODE_LSB     8
`define PAS_ST_SENSE_LSB    10

`define PAS_DATA_OVR        10
`define PAS_DATA_VALID      31

`define PAS_MODE_GND        2'h0
`define PAS_MODE_HALF       2'h1
`define PAS_SENSE_SUPPLY    2'h3

`define PAS_CODE_MIN        10'h000
`define PAS_CODE_MAX        10'h3FF

`endif

/* File: hw/pas_pkg.sv */
`include "pas_params.svh"

package pas_pkg;

    typedef struct packed {
        logic                   over_range_flag;
        logic [`PAS_CODE_W-1:0] code;
    } pas_sample_t;

endpackage

/* File: hw/pas_quantizer.sv */
`timescale 1ns/1ps
`include "pas_params.svh"

module pas_quantizer
    import pas_pkg::*;
#(
    parameter int IN_W = `PAS_IN_W
) (
    input  wire logic signed [IN_W-1:0] i_pos,
    input  wire logic signed [IN_W-1:0] i_neg,
    output pas_sample_t                 o_sample
);

    localparam int DW = IN_W + 1;
    localparam logic signed [DW:0] MID = (DW+1)'(1 << (`PAS_CODE_W - 1));
    localparam logic signed [DW:0] TOP = (DW+1)'((1 << `PAS_CODE_W) - 1);

    logic signed [DW-1:0] diff;
    logic signed [DW:0]   shifted;

    always_comb begin
        // the negative input enters subtracted, so it digitises inverted
        diff     = {i_pos[IN_W-1], i_pos} - {i_neg[IN_W-1], i_neg};
        shifted  = {diff[DW-1], diff} + MID;
        o_sample = '0;
        if (shifted < 0) begin
            o_sample.code = `PAS_CODE_MIN;
            o_sample.over_range_flag  = 1'b1;
        end else if (shifted > TOP) begin
            o_sample.code = `PAS_CODE_MAX;
            o_sample.over_range_flag  = 1'b1;
        end else begin
            o_sample.code = shifted[`PAS_CODE_W-1:0];
            o_sample.over_range_flag  = 1'b0;
        end
    end

endmodule

/* File: hw/pas_fifo.sv */
`timescale 1ns/1ps

module pas_fifo #(
    parameter int W     = 11,
    parameter int DEPTH = 16
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_flush,
    input  wire logic                       i_in_valid,
    output logic                            o_in_ready,
    input  wire logic [W-1:0]               i_in_data,
    output logic                            o_out_valid,
    input  wire logic                       i_out_ready,
    output logic [W-1:0]                    o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]      o_level
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } pas_fifo_st_t;

    pas_fifo_st_t r;
    pas_fifo_st_t n;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    assign o_in_ready  = (r.cnt != CW'(DEPTH));
    assign o_out_valid = (r.cnt != '0);
    assign o_out_data  = mem[r.rp];
    assign o_level     = r.cnt;
    assign push        = i_in_valid & o_in_ready & ~i_flush;
    assign pop         = o_out_valid & i_out_ready & ~i_flush;

    always_comb begin
        n = r;
        if (i_flush) begin
            n = '0;
        end else begin
            if (push) begin
                n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
            end
            if (pop) begin
                n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
            end
            n.cnt = r.cnt + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[r.wp] <= i_in_data;
        end
    end

endmodule

/* File: hw/pas_adc_out.sv */
`timescale 1ns/1ps
`include "pas_params.svh"

module pas_adc_out
    import pas_pkg::*;
#(
    parameter int IN_W       = `PAS_IN_W,
    parameter int LATENCY    = `PAS_LATENCY,
    parameter int FIFO_DEPTH = `PAS_FIFO_DEPTH
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic signed [IN_W-1:0] i_analog_input_pos,
    input  wire logic signed [IN_W-1:0] i_analog_input_neg,
    input  wire logic                   i_out_enable_n,
    input  wire logic                   i_power_down_request,
    input  wire logic [1:0]             i_mode_strap,
    input  wire logic [1:0]             i_bandgap_select_strap,
    output logic [`PAS_CODE_W-1:0]      o_sample_code,
    output logic                        o_sample_oe,
    output logic                        o_sample_valid,
    output logic                        o_over_range_flag,
    output logic                        o_over_range_oe,
    output logic                        o_converting,
    output logic                        o_reference_buffer_en,
    output logic                        o_reference_pins_oe,
    output logic                        o_midscale_bias_output_oe,
    output logic                        o_bandgap_source_en,
    output logic                        o_bandgap_source_oe,
    output logic                        o_capture_ready,
    input  wire logic [`PAS_ADDR_W-1:0] i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [`PAS_DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic [`PAS_DATA_W-1:0]      o_avs_readdata,
    output logic                        o_avs_waitrequest
);

    localparam int CW = $clog2(FIFO_DEPTH+1);
    localparam int SW = $bits(pas_sample_t);

    typedef struct packed {
        pas_sample_t [LATENCY:0]  pipe;
        logic [LATENCY:0]         vld;
        logic [1:0]               mode;
        logic [1:0]               sense;
        logic                     capture;
        logic                     overflow;
        logic                     resp;
        logic [`PAS_DATA_W-1:0]   rdata;
        logic [1:0]               warm;
    } pas_state_t;

    pas_state_t             r;
    pas_state_t             n;
    pas_sample_t            q;
    pas_sample_t            fifo_out;
    logic [SW-1:0]          fifo_out_bits;
    logic                   fifo_valid;
    logic                   fifo_ready;
    logic [CW-1:0]          fifo_level;
    logic                   req;
    logic                   commit;
    logic                   fifo_push;
    logic                   fifo_pop;
    logic                   fifo_flush;
    logic                   ext_ref;
    logic                   bias_on;
    logic                   bandgap_on;
    logic [`PAS_DATA_W-1:0] rd_mux;

    pas_quantizer #(
        .IN_W (IN_W)
    ) u_quant (
        .i_pos    (i_analog_input_pos),
        .i_neg    (i_analog_input_neg),
        .o_sample (q)
    );

    pas_fifo #(
        .W     (SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_flush     (fifo_flush),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (r.pipe[LATENCY]),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_bits),
        .o_level     (fifo_level)
    );

    assign fifo_out = pas_sample_t'(fifo_out_bits);

    // strap decode, straps taken through a flop
    assign ext_ref    = (r.mode == `PAS_MODE_GND);
    assign bias_on    = !ext_ref && (r.mode != `PAS_MODE_HALF);
    assign bandgap_on = (r.sense != `PAS_SENSE_SUPPLY);

    assign req               = i_avs_read | i_avs_write;
    assign commit            = req & r.resp;
    assign o_avs_waitrequest = req & ~r.resp;
    assign o_avs_readdata    = r.rdata;

    assign fifo_push  = r.vld[LATENCY] & r.capture;
    assign fifo_pop   = commit & i_avs_read & (i_avs_address == `PAS_REG_DATA) & fifo_valid;
    assign fifo_flush = commit & i_avs_write & (i_avs_address == `PAS_REG_CTRL)
                        & i_avs_byteenable[0] & i_avs_writedata[`PAS_CTRL_FLUSH];

    always_comb begin
        rd_mux = '0;
        case (i_avs_address)
            `PAS_REG_CTRL: begin
                rd_mux[`PAS_CTRL_CAPTURE] = r.capture;
            end
            `PAS_REG_STATUS: begin
                rd_mux[`PAS_ST_OVERFLOW]   = r.overflow;
                rd_mux[`PAS_ST_EMPTY]      = ~fifo_valid;
                rd_mux[`PAS_ST_FULL]       = ~fifo_ready;
                rd_mux[`PAS_ST_PWRDN]      = i_power_down_request;
                rd_mux[`PAS_ST_EXT_REF]    = ext_ref;
                rd_mux[`PAS_ST_BIAS_ON]    = bias_on;
                rd_mux[`PAS_ST_BANDGAP_ON] = bandgap_on;
                rd_mux[`PAS_ST_VALID]      = r.vld[LATENCY];
                rd_mux[`PAS_ST_MODE_LSB+:2]  = r.mode;
                rd_mux[`PAS_ST_SENSE_LSB+:2] = r.sense;
            end
            `PAS_REG_DATA: begin
                rd_mux[`PAS_DATA_VALID]          = fifo_valid;
                rd_mux[`PAS_DATA_OVR]            = fifo_out.over_range_flag & fifo_valid;
                rd_mux[`PAS_CODE_W-1:0]          = fifo_valid ? fifo_out.code : '0;
            end
            `PAS_REG_LEVEL: begin
                rd_mux[CW-1:0] = fifo_level;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb begin
        n       = r;
        n.mode  = i_mode_strap;
        n.sense = i_bandgap_select_strap;
        // edges since reset, only used to arm the checks
        if (!(&r.warm)) begin
            n.warm = r.warm + 2'h1;
        end
        if (!i_power_down_request) begin
            n.pipe[0] = q;
            n.vld[0]  = 1'b1;
            for (int i = 1; i <= LATENCY; i++) begin
                n.pipe[i] = r.pipe[i-1];
                n.vld[i]  = r.vld[i-1];
            end
        end else begin
            n.vld = '0;
        end
        n.resp = req & ~r.resp;
        if (req & ~r.resp) begin
            n.rdata = i_avs_read ? rd_mux : '0;
        end
        if (commit & i_avs_write & i_avs_byteenable[0]) begin
            if (i_avs_address == `PAS_REG_CTRL) begin
                n.capture = i_avs_writedata[`PAS_CTRL_CAPTURE];
            end
            if ((i_avs_address == `PAS_REG_STATUS) && i_avs_writedata[`PAS_ST_OVERFLOW]) begin
                n.overflow = 1'b0;
            end
        end
        // a dropped sample sets after the clear so it is never lost
        if (fifo_push & ~fifo_ready) begin
            n.overflow = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r         <= '0;
            r.capture <= `PAS_CTRL_RST;
        end else begin
            r <= n;
        end
    end

    assign o_sample_code             = r.pipe[LATENCY].code;
    assign o_over_range_flag         = r.pipe[LATENCY].over_range_flag;
    assign o_sample_valid            = r.vld[LATENCY];
    assign o_sample_oe               = ~i_out_enable_n;
    assign o_over_range_oe           = ~i_out_enable_n;
    assign o_converting              = ~i_power_down_request;
    assign o_reference_buffer_en     = ~ext_ref;
    assign o_reference_pins_oe       = ~ext_ref;
    assign o_midscale_bias_output_oe = bias_on;
    assign o_bandgap_source_en       = bandgap_on;
    assign o_bandgap_source_oe       = bandgap_on;
    assign o_capture_ready           = fifo_ready;

    // checks
    localparam int MID = 1 << (`PAS_CODE_W - 1);
    logic signed [IN_W+1:0] chk_diff;
    logic                   chk_armed;
    // checks wait three edges after reset, while pipeline stages 3 and 4 still hold reset words
    assign chk_armed = &r.warm;
    assign chk_diff = {{2{i_analog_input_pos[IN_W-1]}}, i_analog_input_pos}
                    - {{2{i_analog_input_neg[IN_W-1]}}, i_analog_input_neg};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst || !chk_armed);

    property p_one_per_cycle;
        (!i_power_down_request)[*2] |=> r.vld[0] && r.vld[1] && r.pipe[1] == $past(q, 2);
    endproperty
    a_one_per_cycle: assert property (p_one_per_cycle) else $error("sample not taken each edge");

    property p_latency;
        (!i_power_down_request)[*5] |=> o_sample_code == $past(q.code, 5) && o_sample_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("result not out at fourth edge");

    property p_drive;
        !i_out_enable_n |-> o_sample_oe && o_over_range_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("outputs not driven while enabled");

    property p_release;
        i_out_enable_n |-> !o_sample_oe;
    endproperty
    a_release: assert property (p_release) else $error("data driven while disabled");

    property p_ovr_release;
        i_out_enable_n |-> !o_over_range_oe;
    endproperty
    a_ovr_release: assert property (p_ovr_release) else $error("flag driven while disabled");

    property p_ovr_align;
        (!i_power_down_request)[*5] |=> o_over_range_flag == $past(q.over_range_flag, 5);
    endproperty
    a_ovr_align: assert property (p_ovr_align) else $error("flag not aligned to result");

    property p_saturate;
        (chk_diff < -MID |-> q.code == `PAS_CODE_MIN && q.over_range_flag)
        and (chk_diff > MID - 1 |-> q.code == `PAS_CODE_MAX && q.over_range_flag);
    endproperty
    a_saturate: assert property (p_saturate) else $error("out of range code wrapped");

    property p_unsigned;
        (chk_diff >= -MID && chk_diff < MID)
            |-> !q.over_range_flag && q.code == `PAS_CODE_W'(chk_diff + MID);
    endproperty
    a_unsigned: assert property (p_unsigned) else $error("code not offset binary");

    property p_standby;
        i_power_down_request |-> !o_converting ##1 (!o_sample_valid && $stable(o_sample_code));
    endproperty
    a_standby: assert property (p_standby) else $error("conversion ran in standby");

    property p_ext_ref;
        $past(i_mode_strap) == `PAS_MODE_GND |-> !o_reference_buffer_en && !o_reference_pins_oe;
    endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("buffer on with external refs");

    property p_int_ref;
        $past(i_mode_strap) != `PAS_MODE_GND |-> o_reference_buffer_en
            && o_midscale_bias_output_oe == ($past(i_mode_strap) != `PAS_MODE_HALF);
    endproperty
    a_int_ref: assert property (p_int_ref) else $error("internal ref or bias wrong");

    property p_bandgap;
        $past(i_bandgap_select_strap) == `PAS_SENSE_SUPPLY
            |-> !o_bandgap_source_en && !o_bandgap_source_oe;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap on at supply strap");

    property p_invert;
        (i_analog_input_pos == '0 && chk_diff >= -MID && chk_diff < MID)
            |-> q.code == `PAS_CODE_W'(MID - i_analog_input_neg);
    endproperty
    a_invert: assert property (p_invert) else $error("negative input not inverted");

    c_wake:     cover property (i_power_down_request ##1 (!i_power_down_request)[*5]);
    c_ovr:      cover property (o_over_range_flag && o_sample_oe);
    c_full:     cover property (fifo_push && !fifo_ready);
    c_data_rd:  cover property (fifo_pop);

endmodule

/* File: tb/pas_host_model.sv */
`timescale 1ns/1ps

// host capture side: reads the data pins, discards warm-up words
module pas_host_model (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_power_down_request,
    input  wire logic         i_sample_valid,
    input  wire logic [9:0]   i_data_bus,
    output logic signed [9:0] o_signed_sample,
    output logic              o_accept
);
    logic [2:0] seen_r;

    // top bit inverted turns the unsigned code into twos complement
    assign o_signed_sample = {~i_data_bus[9], i_data_bus[8:0]};

    // words counted again after reset or standby
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seen_r <= 3'h0;
        end else if (i_power_down_request) begin
            seen_r <= 3'h0;
        end else if (i_sample_valid && seen_r != 3'h4) begin
            seen_r <= seen_r + 3'h1;
        end
    end

    assign o_accept = i_sample_valid && seen_r == 3'h4;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "pas_params.svh"

module testbench;
    import pas_pkg::*;
    logic              clk, rst, oe_n, pd, rd, wr;
    logic signed [11:0] pos, neg;
    logic [1:0]        mode, bgs;
    logic [3:0]        addr, be;
    logic [31:0]       wdata, rdata, readdata;
    logic [9:0]        code;
    logic              sample_oe, valid, flag, flag_oe, conv, buf_en, pins_oe;
    logic              bias_oe, bg_en, bg_oe, cap_rdy, waitreq, host_acc;
    logic signed [9:0] host_s;
    int                error_cnt, n_compared, n, d, e;
    int                tp [10] = '{0, -512, 511, -513, 512, 0, 100, -2048, 2047, 0};
    int                tn [10] = '{0, 0, 0, 0, 0, 100, 0, 0, -1, 0};
    wire [9:0]         data_bus = sample_oe ? code : {10{1'bz}};

    pas_adc_out dut_u (
        .i_clk                     (clk),
        .i_sys_rst                 (rst),
        .i_analog_input_pos        (pos),
        .i_analog_input_neg        (neg),
        .i_out_enable_n            (oe_n),
        .i_power_down_request      (pd),
        .i_mode_strap              (mode),
        .i_bandgap_select_strap    (bgs),
        .o_sample_code             (code),
        .o_sample_oe               (sample_oe),
        .o_sample_valid            (valid),
        .o_over_range_flag         (flag),
        .o_over_range_oe           (flag_oe),
        .o_converting              (conv),
        .o_reference_buffer_en     (buf_en),
        .o_reference_pins_oe       (pins_oe),
        .o_midscale_bias_output_oe (bias_oe),
        .o_bandgap_source_en       (bg_en),
        .o_bandgap_source_oe       (bg_oe),
        .o_capture_ready           (cap_rdy),
        .i_avs_address             (addr),
        .i_avs_read                (rd),
        .i_avs_write               (wr),
        .i_avs_writedata           (wdata),
        .i_avs_byteenable          (be),
        .o_avs_readdata            (readdata),
        .o_avs_waitrequest         (waitreq)
    );

    pas_host_model host_u (
        .i_clk                (clk),
        .i_sys_rst            (rst),
        .i_power_down_request (pd),
        .i_sample_valid       (valid),
        .i_data_bus           (data_bus),
        .o_signed_sample      (host_s),
        .o_accept             (host_acc)
    );

    // host supplies the sample clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= dat;
        do begin
            @(posedge clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        if (k >= 50)
            chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
        rdata = readdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rdata);
    endtask

    function automatic int exp_code(input int v);
        if (v < -512)
            return 0;
        if (v > 511)
            return 1023;
        return v + 512;
    endfunction

    initial begin
        #50_000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        pos = 12'h000;
        neg = 12'h000;
        oe_n = 1'b0;
        pd = 1'b0;
        mode = 2'h0;
        bgs = 2'h3;
        addr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0000_0000;
        be = 4'hF;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            for (int b = 0; b < 4; b++) begin
                @(posedge clk);
                mode <= 2'(m);
                bgs <= 2'(b);
                repeat (2) @(posedge clk);
                #1;
                chk("reference_buffer_en", 32'(m != 0), 32'(buf_en));
                chk("reference_pins_oe", 32'(m != 0), 32'(pins_oe));
                chk("midscale_bias_oe", 32'(m >= 2), 32'(bias_oe));
                chk("bandgap_source_en", 32'(b != 3), 32'(bg_en));
                chk("bandgap_source_oe", 32'(b != 3), 32'(bg_oe));
            end
        end
        @(posedge clk);
        mode <= 2'h2;
        bgs <= 2'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            oe_n <= (k == 0);
            #1;
            chk("sample_oe", 32'(k), 32'(sample_oe));
            chk("over_range_oe", 32'(k), 32'(flag_oe));
        end
        // one word per edge, result four edges after capture
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            if (i < 10) begin
                pos <= 12'(tp[i]);
                neg <= 12'(tn[i]);
            end
            #1;
            if (i >= 5) begin
                d = tp[i-5] - tn[i-5];
                e = exp_code(d);
                chk("sample_code", 32'(e), 32'(code));
                chk("over_range", 32'(d < -512 || d > 511), 32'(flag));
                chk("sample_valid", 32'h0000_0001, 32'(valid));
                chk("host signed", 32'(e - 512), 32'(host_s));
            end
        end
        @(posedge clk);
        pd <= 1'b1;
        pos <= 12'h005;
        #1;
        chk("converting", 32'h0000_0000, 32'(conv));
        @(posedge clk);
        #1;
        chk("standby valid", 32'h0000_0000, 32'(valid));
        repeat (3) @(posedge clk);
        pd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (valid !== 1'b1 && n < 20);
        chk("wake latency", 32'h0000_0005, 32'(n));
        n = 0;
        while (host_acc !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("host discard", 32'h0000_0004, 32'(n));
        bus(1'b1, `PAS_REG_CTRL, 32'h0000_0001);
        rchk(`PAS_REG_CTRL, 32'h0000_0001, "ctrl");
        repeat (20) @(posedge clk);
        #1;
        chk("capture_ready", 32'h0000_0000, 32'(cap_rdy));
        rchk(`PAS_REG_STATUS, 32'h0000_02E5, "status full");
        rchk(`PAS_REG_LEVEL, 32'h0000_0010, "level");
        bus(1'b1, `PAS_REG_CTRL, 32'h0000_0000);
        bus(1'b1, `PAS_REG_STATUS, 32'h0000_0001);
        rchk(`PAS_REG_STATUS, 32'h0000_02E4, "status cleared");
        for (int i = 0; i < 16; i++)
            rchk(`PAS_REG_DATA, 32'h8000_0205, "fifo word");
        rchk(`PAS_REG_STATUS, 32'h0000_02E2, "status empty");
        rchk(`PAS_REG_DATA, 32'h0000_0000, "empty pop");
        rchk(4'h2, 32'h0000_0000, "unaligned");
        be <= 4'hE;
        bus(1'b1, `PAS_REG_CTRL, 32'h0000_0001);
        be <= 4'hF;
        rchk(`PAS_REG_CTRL, 32'h0000_0000, "ctrl masked");
        wrap_up();
    end
endmodule
